// ---- rsh_defs.vh ----
`ifndef RSH_DEFS_VH
`define RSH_DEFS_VH
// Register indices: printed offsets not all multiples of four,
// so byte address is four times the printed offset (index)
`define RSH_IDX_RXCFG     12'h01a
`define RSH_IDX_MISC      12'h01c
`define RSH_IDX_PWR       12'h233
`define RSH_IDX_DIVA      12'h300
`define RSH_IDX_DIVB      12'h301
`define RSH_IDX_STAT      12'h302
`define RSH_IDX_IRQ       12'h303
`define RSH_IDX_MASK      12'h304
// Field positions
`define RSH_RX_VCXO_LO    0
`define RSH_RX_VCXO_HI    1
`define RSH_RX_A_SE       5
`define RSH_RX_B_SE       6
`define RSH_RX_A_SEPD     3
`define RSH_RX_B_SEPD     4
`define RSH_MISC_MANSEL   0
`define RSH_MISC_MANUAL   1
`define RSH_MISC_USEPIN   2
`define RSH_MISC_REVERT   3
`define RSH_MISC_MIDSUP   6
`define RSH_MISC_INDEPB   7
`define RSH_PWR_LOOPPD    2
// Reset values
`define RSH_RXCFG_RST     8'h00
`define RSH_MISC_RST      8'h00
`define RSH_PWR_RST       8'h00
`define RSH_DIV_RST       10'h001
// Monitor: clk cycles without a divided edge before a reference is lost
`define RSH_MON_TO        16'h0400
// Interrupt event bits
`define RSH_EV_SWITCH     0
`define RSH_EV_HOLD_IN    1
`define RSH_EV_HOLD_OUT   2
`define RSH_EV_LOSS_A     3
`define RSH_EV_LOSS_B     4
`define RSH_EV_W          5
// Status bits
`define RSH_ST_SEL        0
`define RSH_ST_HOLD       1
`define RSH_ST_OKA        2
`define RSH_ST_OKB        3
`endif

// ---- rsh_ref_switch.v ----
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "rsh_defs.vh"
// How it works
// - Bits 5 and 6 of RXCFG put inputs A and B in single-ended mode.
// - Differential receiver off when not selected or loop powered down.
// - Single-ended buffer off on loop power-down, own power-down, or diff.
// - Divider B uses divider A value unless independent bit 7 set.
// - VCXO feedback receiver mode comes from RXCFG bits 1:0.
// - VCXO feedback receiver off while loop power-down bit is one.
// - Each reference has its own integer divider, 1 to 1023.
// - Monitor judges divided references; its status drives switchover.
// - Manual reference select by register bit or by select pin.
// - Automatic mode goes A to B when A lost and B present.
// - Nonrevertive stays on B when A returns; back to A if B lost.
// - Revertive mode returns to A as soon as A returns.
// - Holdover entered in automatic mode when neither reference present; VCXO keeps running.
// - Charge pump tristated in holdover by default.
// - Holdover left when a reference returns; loop resynchronised.
// - MISC bit 6 forces charge pump to half supply during holdover.
// - Single present input becomes active; with both, one is backup.
module rsh_ref_switch (
   input  wire        clk,
   input  wire        rst_n,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hsel,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        ref_input_a,
   input  wire        ref_input_b,
   input  wire        ref_sel_pin,
   output reg         ref_a_div,
   output reg         ref_b_div,
   output reg         pfd_ref,
   output reg         pfd_ref_sel,
   output reg         holdover,
   output reg         resync,
   output reg         cp_tristate,
   output reg         cp_midsupply,
   output reg         diff_rx_a_pd,
   output reg         diff_rx_b_pd,
   output reg         se_buf_a_pd,
   output reg         se_buf_b_pd,
   output reg         se_mode_a,
   output reg         se_mode_b,
   output reg  [1:0]  vcxo_feedback_input_mode,
   output reg         vcxo_feedback_input_pd,
   output reg         irq
);

   localparam ST_A    = 2'h0;
   localparam ST_B    = 2'h1;
   localparam ST_HOLD = 2'h2;

   reg  [7:0]  rxcfg;
   reg  [7:0]  misc;
   reg  [7:0]  pwr;
   reg  [9:0]  div_a;
   reg  [9:0]  div_b;
   reg  [4:0]  irq_stat;
   reg  [4:0]  irq_mask;
   reg         dp_wr;
   reg         dp_rd;
   reg  [11:0] dp_idx;
   reg  [9:0]  cnt_a;
   reg  [9:0]  cnt_b;
   reg         pa;
   reg         pb;
   reg  [15:0] mon_a;
   reg  [15:0] mon_b;
   reg         ok_a;
   reg         ok_b;
   reg  [1:0]  state;
   reg  [1:0]  next_state;
   reg  [4:0]  next_ev;
   reg  [31:0] next_rdata;
   reg  [9:0]  next_cnt_a;
   reg  [9:0]  next_cnt_b;
   reg         next_a_div;
   reg         next_b_div;
   reg  [15:0] next_mon_a;
   reg  [15:0] next_mon_b;
   reg         next_ok_a;
   reg         next_ok_b;
   reg  [4:0]  next_irq_stat;
   reg         next_holdover;
   reg         next_pfd_ref;
   reg         next_resync;
   reg         next_cp_tristate;
   reg         next_cp_midsupply;
   reg         next_irq;
   reg         next_se_mode_a;
   reg         next_se_mode_b;
   reg         next_diff_rx_a_pd;
   reg         next_diff_rx_b_pd;
   reg         next_se_buf_a_pd;
   reg         next_se_buf_b_pd;
   reg  [1:0]  next_vcxo_mode;
   reg         next_vcxo_pd;

   wire        loop_pd = pwr[`RSH_PWR_LOOPPD];
   wire [9:0]  lim_b   = misc[`RSH_MISC_INDEPB] ? div_b : div_a;
   wire [9:0]  lim_a1  = (div_a == 10'h000) ? 10'h001 : div_a;
   wire [9:0]  lim_b1  = (lim_b == 10'h000) ? 10'h001 : lim_b;
   wire        acc     = hsel & hready & htrans[1];
   wire        man_sel = misc[`RSH_MISC_USEPIN] ? ref_sel_pin
                                                : misc[`RSH_MISC_MANSEL];
   wire        edge_a  = ref_a_div & ~pa;
   wire        edge_b  = ref_b_div & ~pb;

   // AHB-Lite slave, zero wait states
   always @(posedge clk) begin
      if (!rst_n) begin
         dp_wr     <= 1'b0;
         dp_rd     <= 1'b0;
         dp_idx    <= 12'h000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else begin
         dp_wr     <= acc & hwrite;
         dp_rd     <= acc & ~hwrite;
         dp_idx    <= haddr[13:2];
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= (acc & ~hwrite) ? next_rdata : 32'h0000_0000;
      end
   end

   // Read data prepared in the address phase to keep hrdata registered
   always @* begin
      case (haddr[13:2])
         `RSH_IDX_RXCFG: next_rdata = {24'h000000, rxcfg};
         `RSH_IDX_MISC:  next_rdata = {24'h000000, misc};
         `RSH_IDX_PWR:   next_rdata = {24'h000000, pwr};
         `RSH_IDX_DIVA:  next_rdata = {22'h000000, div_a};
         `RSH_IDX_DIVB:  next_rdata = {22'h000000, div_b};
         `RSH_IDX_STAT:  next_rdata = {28'h0000000, ok_b, ok_a,
                                       holdover, pfd_ref_sel};
         `RSH_IDX_IRQ:   next_rdata = {27'h0000000, irq_stat};
         `RSH_IDX_MASK:  next_rdata = {27'h0000000, irq_mask};
         default:        next_rdata = 32'h0000_0000;
      endcase
   end

   // New events win over a write-one clear in the same cycle
   always @* begin
      next_irq_stat = irq_stat | next_ev;
      if (dp_wr && dp_idx == `RSH_IDX_IRQ) begin
         next_irq_stat = (irq_stat & ~hwdata[4:0]) | next_ev;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         rxcfg    <= `RSH_RXCFG_RST;
         misc     <= `RSH_MISC_RST;
         pwr      <= `RSH_PWR_RST;
         div_a    <= `RSH_DIV_RST;
         div_b    <= `RSH_DIV_RST;
         irq_mask <= 5'h00;
         irq_stat <= 5'h00;
      end else begin
         if (dp_wr) begin
            case (dp_idx)
               `RSH_IDX_RXCFG: rxcfg    <= hwdata[7:0];
               `RSH_IDX_MISC:  misc     <= hwdata[7:0];
               `RSH_IDX_PWR:   pwr      <= hwdata[7:0];
               `RSH_IDX_DIVA:  div_a    <= hwdata[9:0];
               `RSH_IDX_DIVB:  div_b    <= hwdata[9:0];
               `RSH_IDX_MASK:  irq_mask <= hwdata[4:0];
               default:        ;
            endcase
         end
         irq_stat <= next_irq_stat;
      end
   end

   // Per-reference dividers, toggle output; divide value 0 acts as 1
   always @* begin
      next_cnt_a = cnt_a;
      next_cnt_b = cnt_b;
      next_a_div = ref_a_div;
      next_b_div = ref_b_div;
      if (ref_input_a && !loop_pd) begin
         if (cnt_a >= lim_a1 - 10'h001) begin
            next_cnt_a = 10'h000;
            next_a_div = ~ref_a_div;
         end else begin
            next_cnt_a = cnt_a + 10'h001;
         end
      end
      if (ref_input_b && !loop_pd) begin
         if (cnt_b >= lim_b1 - 10'h001) begin
            next_cnt_b = 10'h000;
            next_b_div = ~ref_b_div;
         end else begin
            next_cnt_b = cnt_b + 10'h001;
         end
      end
   end

   // Monitor watches divided signals only
   always @* begin
      next_mon_a = mon_a;
      next_mon_b = mon_b;
      next_ok_a  = ok_a;
      next_ok_b  = ok_b;
      if (edge_a) begin
         next_mon_a = 16'h0000;
         next_ok_a  = 1'b1;
      end else if (mon_a == `RSH_MON_TO) begin
         next_ok_a = 1'b0;
      end else begin
         next_mon_a = mon_a + 16'h0001;
      end
      if (edge_b) begin
         next_mon_b = 16'h0000;
         next_ok_b  = 1'b1;
      end else if (mon_b == `RSH_MON_TO) begin
         next_ok_b = 1'b0;
      end else begin
         next_mon_b = mon_b + 16'h0001;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         cnt_a     <= 10'h000;
         cnt_b     <= 10'h000;
         ref_a_div <= 1'b0;
         ref_b_div <= 1'b0;
         pa        <= 1'b0;
         pb        <= 1'b0;
         mon_a     <= 16'h0000;
         mon_b     <= 16'h0000;
         ok_a      <= 1'b0;
         ok_b      <= 1'b0;
      end else begin
         cnt_a     <= next_cnt_a;
         cnt_b     <= next_cnt_b;
         ref_a_div <= next_a_div;
         ref_b_div <= next_b_div;
         pa        <= ref_a_div;
         pb        <= ref_b_div;
         mon_a     <= next_mon_a;
         mon_b     <= next_mon_b;
         ok_a      <= next_ok_a;
         ok_b      <= next_ok_b;
      end
   end

   // Single switchover machine
   always @* begin
      next_state = state;
      case (state)
         ST_A: begin
            if (misc[`RSH_MISC_MANUAL])
               next_state = man_sel ? ST_B : ST_A;
            else if (!ok_a && ok_b)
               next_state = ST_B;
            else if (!ok_a && !ok_b)
               next_state = ST_HOLD;
         end
         ST_B: begin
            if (misc[`RSH_MISC_MANUAL])
               next_state = man_sel ? ST_B : ST_A;
            else if (ok_a && misc[`RSH_MISC_REVERT])
               next_state = ST_A;
            else if (!ok_b && ok_a)
               next_state = ST_A;
            else if (!ok_b && !ok_a)
               next_state = ST_HOLD;
         end
         ST_HOLD: begin
            // Manual mode still needs a live reference to resync
            if (ok_a && (!misc[`RSH_MISC_MANUAL] || !man_sel))
               next_state = ST_A;
            else if (ok_b)
               next_state = ST_B;
         end
         default: next_state = ST_HOLD;
      endcase
   end

   always @* begin
      next_ev = 5'h00;
      next_ev[`RSH_EV_SWITCH]   = (state != ST_HOLD) &&
                                  (next_state != ST_HOLD) &&
                                  (next_state != state);
      next_ev[`RSH_EV_HOLD_IN]  = (state != ST_HOLD) &&
                                  (next_state == ST_HOLD);
      next_ev[`RSH_EV_HOLD_OUT] = (state == ST_HOLD) &&
                                  (next_state != ST_HOLD);
      next_ev[`RSH_EV_LOSS_A]   = ok_a && !edge_a &&
                                  (mon_a == `RSH_MON_TO);
      next_ev[`RSH_EV_LOSS_B]   = ok_b && !edge_b &&
                                  (mon_b == `RSH_MON_TO);
   end

   // Registered outputs of the switchover machine
   always @* begin
      next_holdover     = (next_state == ST_HOLD);
      // Only the chosen divided reference reaches the detector
      next_pfd_ref      = (state == ST_B) ? ref_b_div :
                          (state == ST_A) ? ref_a_div : 1'b0;
      next_resync       = (state == ST_HOLD) &&
                          (next_state != ST_HOLD);
      next_cp_midsupply = (next_state == ST_HOLD) &&
                          misc[`RSH_MISC_MIDSUP];
      next_cp_tristate  = (next_state == ST_HOLD) &&
                          !misc[`RSH_MISC_MIDSUP];
      next_irq          = |(irq_stat & irq_mask);
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         state        <= ST_HOLD;
         pfd_ref_sel  <= 1'b0;
         pfd_ref      <= 1'b0;
         holdover     <= 1'b1;
         resync       <= 1'b0;
         cp_tristate  <= 1'b1;
         cp_midsupply <= 1'b0;
         irq          <= 1'b0;
      end else begin
         state        <= next_state;
         holdover     <= next_holdover;
         if (next_state != ST_HOLD)
            pfd_ref_sel <= (next_state == ST_B);
         pfd_ref      <= next_pfd_ref;
         resync       <= next_resync;
         cp_midsupply <= next_cp_midsupply;
         cp_tristate  <= next_cp_tristate;
         irq          <= next_irq;
      end
   end

   always @* begin
      next_se_mode_a    = rxcfg[`RSH_RX_A_SE];
      next_se_mode_b    = rxcfg[`RSH_RX_B_SE];
      next_diff_rx_a_pd = rxcfg[`RSH_RX_A_SE] | loop_pd;
      next_diff_rx_b_pd = rxcfg[`RSH_RX_B_SE] | loop_pd;
      next_se_buf_a_pd  = loop_pd | rxcfg[`RSH_RX_A_SEPD] |
                          ~rxcfg[`RSH_RX_A_SE];
      next_se_buf_b_pd  = loop_pd | rxcfg[`RSH_RX_B_SEPD] |
                          ~rxcfg[`RSH_RX_B_SE];
      next_vcxo_mode    = rxcfg[`RSH_RX_VCXO_HI:`RSH_RX_VCXO_LO];
      next_vcxo_pd      = loop_pd;
   end

   // Receiver power and mode controls
   always @(posedge clk) begin
      if (!rst_n) begin
         se_mode_a                <= 1'b0;
         se_mode_b                <= 1'b0;
         diff_rx_a_pd             <= 1'b1;
         diff_rx_b_pd             <= 1'b1;
         se_buf_a_pd              <= 1'b1;
         se_buf_b_pd              <= 1'b1;
         vcxo_feedback_input_mode <= 2'h0;
         vcxo_feedback_input_pd   <= 1'b1;
      end else begin
         se_mode_a                <= next_se_mode_a;
         se_mode_b                <= next_se_mode_b;
         diff_rx_a_pd             <= next_diff_rx_a_pd;
         diff_rx_b_pd             <= next_diff_rx_b_pd;
         se_buf_a_pd              <= next_se_buf_a_pd;
         se_buf_b_pd              <= next_se_buf_b_pd;
         vcxo_feedback_input_mode <= next_vcxo_mode;
         vcxo_feedback_input_pd   <= next_vcxo_pd;
      end
   end

endmodule // rsh_ref_switch

// ---- rsh_ref_src.sv ----
`timescale 1ns/1ps
module rsh_ref_src (
   input  wire logic clk,
   input  wire logic en_a,
   input  wire logic en_b,
   output var  logic ref_input_a,
   output var  logic ref_input_b
);
   // A stopped source sits low, like a dead oscillator
   always @(posedge clk) begin
      ref_input_a <= en_a & ~ref_input_a;
      ref_input_b <= en_b & ~ref_input_b;
   end
endmodule // rsh_ref_src

// ---- rsh_properties.sv ----
`timescale 1ns/1ps
`include "rsh_defs.vh"
module rsh_props (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hsel,
   input wire logic        hready,
   input wire logic        pfd_ref,
   input wire logic        pfd_ref_sel,
   input wire logic        holdover,
   input wire logic        resync,
   input wire logic        cp_tristate,
   input wire logic        cp_midsupply,
   input wire logic        diff_rx_a_pd,
   input wire logic        se_buf_b_pd,
   input wire logic        se_mode_a,
   input wire logic        se_mode_b,
   input wire logic [1:0]  vcxo_feedback_input_mode
);
   logic       ph_rx;
   logic [6:0] rx_d;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Data phase of a receiver config write; data kept for a later compare
   always @(posedge clk) begin
      ph_rx <= rst_n & hsel & hready & htrans[1] & hwrite
               & (haddr[13:2] == `RSH_IDX_RXCFG);
      if (ph_rx) rx_d <= hwdata[6:0];
   end
   AST_SE_MODE: assert property (
      ph_rx |-> ##2 {se_mode_b, se_mode_a} == rx_d[6:5])
      else $error("single-ended mode wrong");
   AST_DIFF_PD: assert property (se_mode_a |-> diff_rx_a_pd)
      else $error("diff receiver left on");
   AST_SE_PD: assert property (!se_mode_b |-> se_buf_b_pd)
      else $error("se buffer left on");
   AST_VCXO_MODE: assert property (
      ph_rx |-> ##2 vcxo_feedback_input_mode == rx_d[1:0])
      else $error("vcxo mode wrong");
   AST_PFD_QUIET: assert property (
      holdover && $past(holdover) |-> !pfd_ref)
      else $error("pfd fed in holdover");
   AST_CP_HOLD: assert property (
      (cp_tristate || cp_midsupply) |-> holdover || $past(holdover))
      else $error("charge pump parked outside holdover");
   AST_RESYNC: assert property ($fell(holdover) |-> ##[0:1] resync)
      else $error("no resync on exit");
   AST_SEL_HOLD: assert property (
      holdover && $past(holdover) |-> $stable(pfd_ref_sel))
      else $error("select moved in holdover");
endmodule // rsh_props
bind rsh_ref_switch rsh_props u_props (.clk, .rst_n, .haddr, .htrans, .hwrite,
   .hwdata, .hsel, .hready, .pfd_ref, .pfd_ref_sel, .holdover, .resync,
   .cp_tristate, .cp_midsupply, .diff_rx_a_pd, .se_buf_b_pd, .se_mode_a,
   .se_mode_b, .vcxo_feedback_input_mode);

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "rsh_defs.vh"
module tb_top;
   logic        clk = 0, rst_n = 0, hwrite = 0, hsel = 0, rd_ph = 0;
   logic        ref_sel_pin = 0, en_a = 0, en_b = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, v;
   logic [31:0] q[$];
   int          miscompares = 0, tests_run = 0, seed = 44182, n;
   wire  [31:0] hrdata;
   wire  [1:0]  vcxo_feedback_input_mode;
   wire         hreadyout, ref_input_a, ref_input_b, pfd_ref, pfd_ref_sel;
   wire         holdover, cp_tristate, cp_midsupply, diff_rx_a_pd, irq;
   wire         se_buf_b_pd, se_mode_a, vcxo_feedback_input_pd;
   wire         diff_rx_b_pd, se_buf_a_pd;
   rsh_ref_src u_src (.clk, .en_a, .en_b, .ref_input_a, .ref_input_b);
   rsh_ref_switch u_dut (.clk, .rst_n, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hsel, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp(), .ref_input_a, .ref_input_b, .ref_sel_pin, .ref_a_div(),
      .ref_b_div(), .pfd_ref, .pfd_ref_sel, .holdover, .resync(),
      .cp_tristate, .cp_midsupply, .diff_rx_a_pd, .diff_rx_b_pd,
      .se_buf_a_pd, .se_buf_b_pd, .se_mode_a, .se_mode_b(),
      .vcxo_feedback_input_mode, .vcxo_feedback_input_pd, .irq);
   always #10 clk = ~clk;
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task close_out;
      $display("mismatches %0d of %0d checks", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Trailing idle cycle between transfers; a written register has already been updated before the task returns
   task xfer(input logic [11:0] i, input logic w, input logic [31:0] d);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {18'h0, i, 2'h0};
      @(posedge clk);
      while (!hreadyout) @(posedge clk);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (!hreadyout) @(posedge clk);
      @(posedge clk);
   endtask
   task wr(input logic [11:0] i, input logic [31:0] d);
      xfer(i, 1'b1, d);
   endtask
   task rd(input logic [11:0] i, input logic [31:0] e);
      q.push_back(e);
      xfer(i, 1'b0, 32'h0);
   endtask
   // Read data is judged in its data phase against the oldest note
   always @(posedge clk) begin
      if (rd_ph) chk(hrdata, q.pop_front());
      rd_ph <= hsel & htrans[1] & ~hwrite & hreadyout;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      close_out;
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      chk({holdover, cp_tristate}, 3);
      rd(`RSH_IDX_DIVA, 1);
      rd(12'h3ff, 0);
      repeat (4) begin
         v = $random(seed) & 32'h7b;
         wr(`RSH_IDX_RXCFG, v);
         rd(`RSH_IDX_RXCFG, v);
         chk(se_mode_a, v[5]);
         chk(diff_rx_a_pd, v[5]);
         chk(se_buf_b_pd, !v[6] | v[4]);
         chk(diff_rx_b_pd, v[6]);
         chk(se_buf_a_pd, !v[5] | v[3]);
         chk(vcxo_feedback_input_mode, v[1:0]);
      end
      wr(`RSH_IDX_RXCFG, 0);
      wr(`RSH_IDX_PWR, 4);
      rd(`RSH_IDX_PWR, 4);
      chk({vcxo_feedback_input_pd, diff_rx_a_pd, se_buf_b_pd}, 7);
      wr(`RSH_IDX_PWR, 0);
      en_a <= 1;
      en_b <= 1;
      for (n = 0; n < 400 && holdover !== 0; n++) @(posedge clk);
      chk({holdover, pfd_ref_sel}, 0);
      wr(`RSH_IDX_IRQ, 32'h1f);
      rd(`RSH_IDX_STAT, 32'hc);
      en_a <= 0;
      for (n = 0; n < 3000 && pfd_ref_sel !== 1; n++) @(posedge clk);
      chk(pfd_ref_sel, 1);
      rd(`RSH_IDX_IRQ, 32'h9);
      chk(irq, 0);
      wr(`RSH_IDX_MASK, 1);
      rd(`RSH_IDX_MASK, 1);
      chk(irq, 1);
      wr(`RSH_IDX_IRQ, 9);
      rd(`RSH_IDX_IRQ, 0);
      chk(irq, 0);
      en_a <= 1;
      repeat (200) @(posedge clk);
      chk(pfd_ref_sel, 1);
      wr(`RSH_IDX_MISC, 8);
      for (n = 0; n < 400 && pfd_ref_sel !== 0; n++) @(posedge clk);
      chk(pfd_ref_sel, 0);
      en_a <= 0;
      en_b <= 0;
      for (n = 0; n < 3000 && holdover !== 1; n++) @(posedge clk);
      @(posedge clk);
      chk({holdover, cp_tristate, pfd_ref}, 6);
      rd(`RSH_IDX_IRQ, 32'h1b);
      wr(`RSH_IDX_IRQ, 32'h1f);
      wr(`RSH_IDX_MISC, 32'h48);
      rd(`RSH_IDX_MISC, 32'h48);
      chk({cp_midsupply, cp_tristate}, 2);
      en_b <= 1;
      for (n = 0; n < 400 && holdover !== 0; n++) @(posedge clk);
      chk({holdover, pfd_ref_sel}, 1);
      rd(`RSH_IDX_IRQ, 32'h4);
      wr(`RSH_IDX_MISC, 2);
      rd(`RSH_IDX_MISC, 2);
      chk(pfd_ref_sel, 0);
      ref_sel_pin <= 1;
      wr(`RSH_IDX_MISC, 6);
      rd(`RSH_IDX_MISC, 6);
      chk(pfd_ref_sel, 1);
      en_a <= 1;
      wr(`RSH_IDX_MISC, 0);
      wr(`RSH_IDX_DIVA, 32'hffff);
      rd(`RSH_IDX_DIVA, 32'h3ff);
      for (n = 0; n < 4000 && holdover !== 1; n++) @(posedge clk);
      chk(holdover, 1);
      wr(`RSH_IDX_MISC, 32'h80);
      for (n = 0; n < 400 && holdover !== 0; n++) @(posedge clk);
      chk({holdover, pfd_ref_sel}, 1);
      close_out;
   end
endmodule // tb_top
